// *** logic/hps_host.sv ***
// host-side sequencer for the 16-bit sram-like port of the ethernet controller
// assumes the device pins are asynchronous to ref_clk; read data pass two flops before use
`include "hps_cfg.svh"

module hps_host (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic              req_write,
  input  wire hps_pkg::hps_res_e req_kind,
  input  wire logic [6:0]        req_addr,
  input  wire logic              req_fifo_direct,
  input  wire logic              req_burst,
  input  wire logic [15:0]       req_wdata,
  input  wire logic              probe_enable,
  output logic                   rsp_valid,
  output logic [15:0]            rsp_rdata,
  output logic                   host_select_n,
  output logic                   read_strobe_n,
  output logic                   write_strobe_n,
  output logic [6:0]             host_addr,
  output logic                   fifo_sel,
  output logic [15:0]            data_out,
  output logic                   data_out_en_n,
  input  wire logic [15:0]       data_in
);

  hps_pkg::hps_state_e    state;
  hps_pkg::hps_state_e    next_state;
  hps_pkg::hps_res_e      cur_kind;
  logic [3:0]             cnt;
  logic [4:0]             burst_words;
  logic                   is_probe;
  logic                   was_write;
  logic [15:0]            din_meta;
  logic [15:0]            din_sync;
  logic [`HPS_GAP_W-1:0]  gap_elapsed [`HPS_GAP_N];
  logic [`HPS_GAP_N-1:0]  gap_event;
  logic [`HPS_GAP_W-1:0]  need_wr;
  logic                   rr_ok;
  logic                   gap_ok;
  logic                   launch;
  logic                   probe_go;
  logic                   cont;
  logic                   rd_done;
  logic                   wr_done;
  logic                   burst_room;

  // read data synchroniser; only the second stage is looked at
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      din_meta <= 16'h0000;
      din_sync <= 16'h0000;
    end else begin
      din_meta <= data_in;
      din_sync <= din_meta;
    end
  end

  // read-after-write wait for the resource about to be read
  always_comb begin
    unique case (req_kind)
      hps_pkg::HPS_RES_PWR_MGMT:   need_wr = `HPS_GAP_W'(`HPS_WAIT_PWR_CYC);
      hps_pkg::HPS_RES_FREE_RUN:   need_wr = `HPS_GAP_W'(`HPS_WAIT_FREE_CYC);
      hps_pkg::HPS_RES_IRQ_CFG,
      hps_pkg::HPS_RES_TX_LEVEL,
      hps_pkg::HPS_RES_GP_TIMER:   need_wr = `HPS_GAP_W'(`HPS_WAIT_MID_CYC);
      hps_pkg::HPS_RES_INT_STATUS: need_wr = `HPS_GAP_W'(`HPS_WAIT_STS_CYC);
      hps_pkg::HPS_RES_INT_ENABLE,
      hps_pkg::HPS_RES_OTHER_CFG:  need_wr = `HPS_GAP_W'(`HPS_WAIT_CFG_CYC);
      hps_pkg::HPS_RES_IDENTITY,
      hps_pkg::HPS_RES_PROBE,
      hps_pkg::HPS_RES_RX_LEVEL,
      hps_pkg::HPS_RES_RX_DROP,
      hps_pkg::HPS_RES_RX_DATA,
      hps_pkg::HPS_RES_RX_STATUS,
      hps_pkg::HPS_RES_TX_STATUS,
      hps_pkg::HPS_RES_TX_DATA:    need_wr = '0;
    endcase
  end

  // read-after-read pairs: level and counter indications lag the read that moved them
  // a burst word that is itself the event restarts its tracker only at the next edge,
  // so while the event is up the stale count must not let a continuation through
  assign rr_ok = (req_kind == hps_pkg::HPS_RES_RX_LEVEL) ?
                   ((gap_elapsed[1] >= `HPS_GAP_W'(`HPS_RR_LEVEL_CYC)) & ~gap_event[1]) :
                 (req_kind == hps_pkg::HPS_RES_TX_LEVEL) ?
                   ((gap_elapsed[2] >= `HPS_GAP_W'(`HPS_RR_LEVEL_CYC)) & ~gap_event[2]) :
                 (req_kind == hps_pkg::HPS_RES_RX_DROP) ?
                   ((gap_elapsed[3] >= `HPS_GAP_W'(`HPS_RR_DROP_CYC)) & ~gap_event[3]) :
                   1'b1;

  // writes never wait; reads wait for both the write gap and their read pair gap
  assign gap_ok     = req_write | ((gap_elapsed[0] >= need_wr) & rr_ok);
  assign launch     = (state == hps_pkg::HPS_ST_IDLE) & req_valid & gap_ok;
  // probes fill the wait; the timers count real time, so slow probes simply need fewer
  assign probe_go   = (state == hps_pkg::HPS_ST_IDLE) & req_valid & ~gap_ok & probe_enable;
  assign rd_done    = (state == hps_pkg::HPS_ST_RD_ACT) & (cnt == 4'h0);
  assign wr_done    = (state == hps_pkg::HPS_ST_WR_ACT) & (cnt == 4'h0);
  // plain bursts stop at 16 words, fifo-direct bursts run on
  assign burst_room = fifo_sel | (burst_words < 5'(`HPS_BURST_WORDS - 1));
  assign cont       = rd_done & ~is_probe & req_valid & ~req_write & req_burst & gap_ok &
                      (req_fifo_direct == fifo_sel) & burst_room;
  assign req_ready  = launch | cont;

  // events that restart the gap trackers
  assign gap_event[0] = wr_done;
  assign gap_event[1] = rd_done & ((cur_kind == hps_pkg::HPS_RES_RX_DATA) |
                                   (cur_kind == hps_pkg::HPS_RES_RX_STATUS));
  assign gap_event[2] = rd_done & (cur_kind == hps_pkg::HPS_RES_TX_STATUS);
  assign gap_event[3] = rd_done & (cur_kind == hps_pkg::HPS_RES_RX_DROP);

  // one elapsed-time tracker per spacing source
  for (genvar g = 0; g < `HPS_GAP_N; g++) begin : gen_gap
    hps_gap_timer u_gap (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .restart (gap_event[g]),
      .elapsed (gap_elapsed[g])
    );
  end

  // cycle sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      hps_pkg::HPS_ST_IDLE: begin
        if (launch && req_write) begin
          next_state = hps_pkg::HPS_ST_WR_ACT;
        end else if (launch || probe_go) begin
          next_state = hps_pkg::HPS_ST_RD_ACT;
        end
      end
      hps_pkg::HPS_ST_RD_ACT: begin
        if (rd_done && !cont) begin
          next_state = hps_pkg::HPS_ST_RECOVER;
        end
      end
      hps_pkg::HPS_ST_WR_ACT: begin
        if (wr_done) begin
          next_state = hps_pkg::HPS_ST_RECOVER;
        end
      end
      hps_pkg::HPS_ST_RECOVER: begin
        if (cnt == 4'h0) begin
          next_state = hps_pkg::HPS_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= hps_pkg::HPS_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // phase counter: strobe low time, then the 13 ns release before the next cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
    end else if ((launch && !req_write) || probe_go || cont) begin
      cnt <= 4'(`HPS_RD_HOLD_CYC - 1);
    end else if (launch) begin
      cnt <= 4'(`HPS_WR_LOW_CYC - 1);
    end else if (rd_done || wr_done) begin
      cnt <= 4'(`HPS_RELEASE_CYC - 1);
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end

  // per-cycle attributes latched when a cycle or burst word is taken
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_kind    <= hps_pkg::HPS_RES_IDENTITY;
      is_probe    <= 1'b0;
      was_write   <= 1'b0;
      burst_words <= 5'h00;
    end else if (launch || cont) begin
      cur_kind    <= req_kind;
      is_probe    <= 1'b0;
      was_write   <= req_write;
      burst_words <= cont ? burst_words + 5'h01 : 5'h00;
    end else if (probe_go) begin
      cur_kind    <= hps_pkg::HPS_RES_PROBE;
      is_probe    <= 1'b1;
      was_write   <= 1'b0;
      burst_words <= 5'h00;
    end
  end

  // pins come from flops; a burst keeps select and read strobe low while the address steps
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_select_n  <= 1'b1;
      read_strobe_n  <= 1'b1;
      write_strobe_n <= 1'b1;
      host_addr      <= 7'h00;
      fifo_sel       <= 1'b0;
      data_out       <= 16'h0000;
      data_out_en_n  <= 1'b1;
    end else begin
      host_select_n  <= (next_state != hps_pkg::HPS_ST_RD_ACT) &&
                        (next_state != hps_pkg::HPS_ST_WR_ACT);
      read_strobe_n  <= (next_state != hps_pkg::HPS_ST_RD_ACT);
      write_strobe_n <= (next_state != hps_pkg::HPS_ST_WR_ACT);
      // data keeps driving through the release so hold time is met
      data_out_en_n  <= !((next_state == hps_pkg::HPS_ST_WR_ACT) ||
                          (next_state == hps_pkg::HPS_ST_RECOVER && was_write) ||
                          (launch && req_write));
      if (launch || cont) begin
        host_addr <= req_addr;
        fifo_sel  <= req_fifo_direct;
        data_out  <= req_wdata;
      end else if (probe_go) begin
        host_addr <= `HPS_PROBE_ADDR;
        fifo_sel  <= 1'b0;
      end
    end
  end

  // read answer; probe reads are spent silently
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
    end else begin
      rsp_valid <= rd_done && !is_probe;
      if (rd_done && !is_probe) begin
        rsp_rdata <= din_sync;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_rd_start;
    launch && !req_write;
  endsequence

  sequence s_rd_word;
    (!read_strobe_n && !host_select_n)[*7];
  endsequence

  chk_pwr_read_gap: assert property (s_rd_start and (req_kind == hps_pkg::HPS_RES_PWR_MGMT)
    |-> gap_elapsed[0] >= 6'd40) else $error("power control read too soon after write");
  chk_status_read_gap: assert property (s_rd_start and (req_kind == hps_pkg::HPS_RES_INT_STATUS)
    |-> gap_elapsed[0] >= 6'd12) else $error("interrupt status read too soon after write");
  chk_cfg_read_gap: assert property (s_rd_start and (req_kind == hps_pkg::HPS_RES_INT_ENABLE)
    |-> gap_elapsed[0] >= 6'd6) else $error("enable register read too soon after write");
  chk_rx_level_gap: assert property (s_rd_start and (req_kind == hps_pkg::HPS_RES_RX_LEVEL)
    |-> gap_elapsed[1] >= 6'd17) else $error("rx level read too soon after rx fifo read");
  chk_tx_level_gap: assert property (s_rd_start and (req_kind == hps_pkg::HPS_RES_TX_LEVEL)
    |-> gap_elapsed[2] >= 6'd17 && gap_elapsed[0] >= 6'd17) else $error("tx level read too soon");
  chk_drop_reread_gap: assert property (s_rd_start and (req_kind == hps_pkg::HPS_RES_RX_DROP)
    |-> gap_elapsed[3] >= 6'd23) else $error("discard counter reread too soon");
  chk_read_word_shape: assert property (s_rd_start |=> s_rd_word ##1 rsp_valid)
    else $error("read word shape or answer timing wrong");
  chk_write_shape: assert property (launch && req_write
    |=> (!write_strobe_n && !data_out_en_n)[*4] ##1 (write_strobe_n && !data_out_en_n))
    else $error("write strobe shape wrong");
  chk_probe_silent: assert property (probe_go
    |=> (host_addr == `HPS_PROBE_ADDR && !read_strobe_n)[*7] ##1 !rsp_valid)
    else $error("probe read misshaped or answered");
  chk_strobe_excl: assert property (!(!read_strobe_n && !write_strobe_n))
    else $error("read and write strobes low together");

endmodule : hps_host

// *** logic/hps_cfg.svh ***
// timing and address constants for the host-side port sequencer
// assumes a 125 MHz ref_clk; every wait is given in ns and turned into cycles here
//
// Operation
// - reads are single, burst, fifo-direct single or fifo-direct burst, strobe controlled
// - writes are ordinary register writes or fifo-direct writes using select and write strobe
// - host leaves an idle gap between a write and the next read
// - after write wait 315 power, 180 counter, 135 irq/tx level/timer, 90 status
// - after write wait 45 ns for config; none for identity, probe, rx level, drop
// - a wait may be filled with dummy reads of the byte-order probe
// - slower dummy reads may be fewer while total elapsed time still covers the wait
// - host spaces certain back-to-back read pairs by a minimum time
// - after rx data or rx status read wait 135 ns before rx level read
// - after tx status read wait 135 ns before tx level read
// - after a discard counter read wait 180 ns before reading it again
`ifndef HPS_CFG_SVH
`define HPS_CFG_SVH

`define HPS_CLK_NS        8
`define HPS_NS2CYC(ns)    (((ns) + `HPS_CLK_NS - 1) / `HPS_CLK_NS)

// read-after-write waits
`define HPS_WAIT_PWR_NS   315
`define HPS_WAIT_FREE_NS  180
`define HPS_WAIT_MID_NS   135
`define HPS_WAIT_STS_NS   90
`define HPS_WAIT_CFG_NS   45
`define HPS_WAIT_PWR_CYC  `HPS_NS2CYC(`HPS_WAIT_PWR_NS)
`define HPS_WAIT_FREE_CYC `HPS_NS2CYC(`HPS_WAIT_FREE_NS)
`define HPS_WAIT_MID_CYC  `HPS_NS2CYC(`HPS_WAIT_MID_NS)
`define HPS_WAIT_STS_CYC  `HPS_NS2CYC(`HPS_WAIT_STS_NS)
`define HPS_WAIT_CFG_CYC  `HPS_NS2CYC(`HPS_WAIT_CFG_NS)

// read-after-read waits
`define HPS_RR_LEVEL_NS   135
`define HPS_RR_DROP_NS    180
`define HPS_RR_LEVEL_CYC  `HPS_NS2CYC(`HPS_RR_LEVEL_NS)
`define HPS_RR_DROP_CYC   `HPS_NS2CYC(`HPS_RR_DROP_NS)

// strobe shaping: read hold covers 40 ns data valid plus two sync stages
`define HPS_SYNC_STAGES   2
`define HPS_RD_VALID_NS   40
`define HPS_RD_HOLD_CYC   (`HPS_NS2CYC(`HPS_RD_VALID_NS) + `HPS_SYNC_STAGES)
`define HPS_WR_LOW_NS     32
`define HPS_WR_LOW_CYC    `HPS_NS2CYC(`HPS_WR_LOW_NS)
`define HPS_RELEASE_NS    13
`define HPS_RELEASE_CYC   `HPS_NS2CYC(`HPS_RELEASE_NS)
`define HPS_BURST_WORDS   16

// gap trackers: 0 any write, 1 rx data/status read, 2 tx status read, 3 discard counter read
`define HPS_GAP_N         4
`define HPS_GAP_W         6
`define HPS_GAP_MAX       6'h3f

// word address of the byte-order probe register
`define HPS_PROBE_ADDR    7'h32

`endif

// *** logic/hps_pkg.sv ***
// types for the host-side port sequencer
// constants live in hps_cfg.svh
package hps_pkg;

  // class of the resource addressed by a request; selects the spacing to apply
  typedef enum logic [3:0] {
    HPS_RES_IDENTITY,
    HPS_RES_PROBE,
    HPS_RES_RX_LEVEL,
    HPS_RES_RX_DROP,
    HPS_RES_IRQ_CFG,
    HPS_RES_INT_STATUS,
    HPS_RES_INT_ENABLE,
    HPS_RES_TX_LEVEL,
    HPS_RES_PWR_MGMT,
    HPS_RES_GP_TIMER,
    HPS_RES_FREE_RUN,
    HPS_RES_OTHER_CFG,
    HPS_RES_RX_DATA,
    HPS_RES_RX_STATUS,
    HPS_RES_TX_STATUS,
    HPS_RES_TX_DATA
  } hps_res_e;

  typedef enum logic [1:0] {
    HPS_ST_IDLE,
    HPS_ST_RD_ACT,
    HPS_ST_WR_ACT,
    HPS_ST_RECOVER
  } hps_state_e;

endpackage : hps_pkg

// *** logic/hps_gap_timer.sv ***
// saturating elapsed-time counter, restarted by an event pulse
// assumes restart comes from logic on ref_clk
`include "hps_cfg.svh"

module hps_gap_timer (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic                  restart,
  output logic [`HPS_GAP_W-1:0]      elapsed
);

  // starts saturated so nothing waits after reset; saturation keeps old events harmless
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      elapsed <= `HPS_GAP_MAX;
    end else if (restart) begin
      elapsed <= '0;
    end else if (elapsed != `HPS_GAP_MAX) begin
      elapsed <= elapsed + `HPS_GAP_W'(1);
    end
  end

endmodule : hps_gap_timer

// *** verif/hps_dev_model.sv ***
// device side of the 16-bit host port: register file, fifo counters and delayed level updates
// assumes pins come from hps_host on ref_clk; lat sets how slowly read data become valid
module hps_dev_model #(
  parameter logic [6:0] TX_LVL = 7'h1c,
  parameter logic [6:0] RX_LVL = 7'h08,
  parameter logic [6:0] DROP   = 7'h0c
) (
  input  wire logic        ref_clk,
  input  wire logic [1:0]  lat,
  input  wire logic        host_select_n,
  input  wire logic        read_strobe_n,
  input  wire logic        write_strobe_n,
  input  wire logic [6:0]  host_addr,
  input  wire logic        fifo_sel,
  input  wire logic [15:0] data_out,
  input  wire logic        data_out_en_n,
  output logic      [15:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:127];
  logic [15:0] word, w_data, n_tx, n_rx, n_drop, tx_seen, rx_seen, drop_seen;
  logic [6:0]  addr_q, w_addr;
  logic        fifo_q, w_fifo, wr_q, rd_q;
  logic [1:0]  age;
  wire         rd_act  = !host_select_n && !read_strobe_n;
  wire         wr_act  = !host_select_n && !write_strobe_n;
  wire         relatch = rd_act && (!rd_q || host_addr !== addr_q || fifo_sel !== fifo_q);

  initial begin
    for (int i = 0; i < 128; i++) mem[i] = {9'h000, 7'(i)};
    {word, n_tx, n_rx, n_drop, tx_seen, rx_seen, drop_seen} = '0;
    {addr_q, fifo_q, wr_q, rd_q, age} = '0;
  end

  // writes take effect when the strobe ends
  always @(posedge ref_clk) begin
    wr_q <= wr_act;
    rd_q <= rd_act;
    if (wr_act && !data_out_en_n) begin
      w_addr <= host_addr;
      w_fifo <= fifo_sel;
      w_data <= data_out;
    end
    if (wr_q && !wr_act && w_fifo) begin
      n_tx    <= n_tx + 16'h0001;
      tx_seen <= #135 n_tx + 16'h0001; // slowest allowed, so an early read sees stale level
    end
    if (wr_q && !wr_act && !w_fifo) mem[w_addr] <= w_data;
    // counters are latched as each word starts; a new address inside a burst starts a word
    if (relatch) begin
      age    <= 2'h0;
      addr_q <= host_addr;
      fifo_q <= fifo_sel;
      word   <= fifo_sel ? 16'hc000 + n_rx : host_addr == TX_LVL ? tx_seen :
                host_addr == RX_LVL ? 16'h0100 - rx_seen : host_addr == DROP ? drop_seen : mem[host_addr];
      n_rx   <= n_rx + {15'h0000, fifo_sel};
      n_drop <= n_drop + {15'h0000, !fifo_sel && host_addr == DROP};
    end else if (rd_act && age != 2'h3) age <= age + 2'h1;
    if (rd_q && !rd_act) begin
      rx_seen   <= #135 n_rx;
      drop_seen <= #180 n_drop;
    end
  end

  // invalid or released bus shows the inverse, never a lucky copy of the word
  assign data_in = (rd_act && !relatch && age >= lat) ? word : ~word;
endmodule : hps_dev_model

// *** verif/testbench.sv ***
// self-checking bench: hps_host drives the device model, reads are checked through a queue
// assumes hps_pkg, hps_cfg.svh and hps_host are compiled before this file
`include "hps_cfg.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic              ref_clk, rst_n, req_valid, req_ready, req_write, req_fifo_direct, req_burst;
  logic              probe_enable, rsp_valid, host_select_n, read_strobe_n, write_strobe_n;
  logic              fifo_sel, data_out_en_n, rd_prev = 1'b1, wr_prev = 1'b1;
  logic [1:0]        lat;
  logic [6:0]        req_addr, host_addr, addr_prev;
  logic [15:0]       req_wdata, rsp_rdata, data_out, data_in, n_tx, n_rx, n_drop;
  logic [15:0]       exp_q [$];
  logic [15:0]       shadow [0:127];
  hps_pkg::hps_res_e req_kind;
  hps_pkg::hps_res_e kind_of [0:127];
  int                n_errors, tests_run, cycles;
  real               t_wr, t_rx, t_txs, t_drop;

  hps_host dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_kind(req_kind), .req_addr(req_addr), .req_fifo_direct(req_fifo_direct),
    .req_burst(req_burst), .req_wdata(req_wdata), .probe_enable(probe_enable), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .host_select_n(host_select_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .host_addr(host_addr), .fifo_sel(fifo_sel), .data_out(data_out),
    .data_out_en_n(data_out_en_n), .data_in(data_in));
  hps_dev_model #(.TX_LVL(7'h1c), .RX_LVL(7'h08), .DROP(7'h0c)) dev_u (.ref_clk(ref_clk), .lat(lat),
    .host_select_n(host_select_n), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .host_addr(host_addr), .fifo_sel(fifo_sel), .data_out(data_out), .data_out_en_n(data_out_en_n),
    .data_in(data_in));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic close_out();
    if (n_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out

  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // wait after any write before reading each class
  function automatic real wait_ns(hps_pkg::hps_res_e k);
    case (k)
      hps_pkg::HPS_RES_PWR_MGMT:   return 315.0;
      hps_pkg::HPS_RES_FREE_RUN:   return 180.0;
      hps_pkg::HPS_RES_IRQ_CFG, hps_pkg::HPS_RES_TX_LEVEL, hps_pkg::HPS_RES_GP_TIMER: return 135.0;
      hps_pkg::HPS_RES_INT_STATUS: return 90.0;
      hps_pkg::HPS_RES_INT_ENABLE, hps_pkg::HPS_RES_OTHER_CFG: return 45.0;
      default:                     return 0.0;
    endcase
  endfunction : wait_ns

  // one request held until taken; the expected answer of a read is noted at issue
  task automatic req(logic wr, hps_pkg::hps_res_e k, logic [6:0] a, logic fd, logic bst, logic [15:0] d);
    int n;
    n = 0;
    @(negedge ref_clk);
    req_valid       = 1'b1;
    req_write       = wr;
    req_kind        = k;
    req_addr        = a;
    req_fifo_direct = fd;
    req_burst       = bst;
    req_wdata       = d;
    probe_enable = 1'($urandom);
    lat = 2'($urandom_range(2));
    kind_of[a] = k;
    if (wr && fd) begin
      n_tx++;
    end else if (wr) begin
      shadow[a] = d;
    end else if (fd) begin
      exp_q.push_back(16'hc000 + n_rx);
      n_rx++;
    end else if (k == hps_pkg::HPS_RES_TX_LEVEL) begin
      exp_q.push_back(n_tx);
    end else if (k == hps_pkg::HPS_RES_RX_LEVEL) begin
      exp_q.push_back(16'h0100 - n_rx);
    end else if (k == hps_pkg::HPS_RES_RX_DROP) begin
      exp_q.push_back(n_drop);
      n_drop++;
    end else begin
      exp_q.push_back(shadow[a]);
    end
    do @(posedge ref_clk); while (req_ready !== 1'b1 && n++ < 300);
    if (n >= 300) check("request taken", 16'h0001, 16'h0000);
  endtask : req

  // answers are compared in issue order; an answer with nothing noted fails
  always @(posedge ref_clk) if (rsp_valid === 1'b1) begin
    check("read data", exp_q.size() > 0 ? exp_q.pop_front() : ~rsp_rdata, rsp_rdata);
  end

  // pin watcher; edges are seen one clock late, which shifts every stamp alike
  always @(posedge ref_clk) begin
    rd_prev <= read_strobe_n;
    wr_prev <= write_strobe_n;
    addr_prev <= host_addr;
    cycles <= cycles + 1;
    if (!wr_prev && write_strobe_n) t_wr = $realtime;
    if (!rd_prev && read_strobe_n && kind_of[addr_prev] inside {hps_pkg::HPS_RES_RX_DATA, hps_pkg::HPS_RES_RX_STATUS}) t_rx = $realtime;
    if (!rd_prev && read_strobe_n && kind_of[addr_prev] == hps_pkg::HPS_RES_TX_STATUS) t_txs = $realtime;
    if (!rd_prev && read_strobe_n && kind_of[addr_prev] == hps_pkg::HPS_RES_RX_DROP) t_drop = $realtime;
    if (rd_prev && !read_strobe_n && host_addr !== `HPS_PROBE_ADDR) begin
      check("write to read gap", 16'h0001, {15'h0000, $realtime - t_wr >= wait_ns(kind_of[host_addr])});
      if (kind_of[host_addr] == hps_pkg::HPS_RES_RX_LEVEL) check("rx level gap", 16'h0001, {15'h0000, $realtime - t_rx >= 135.0});
      if (kind_of[host_addr] == hps_pkg::HPS_RES_TX_LEVEL) check("tx level gap", 16'h0001, {15'h0000, $realtime - t_txs >= 135.0});
      if (kind_of[host_addr] == hps_pkg::HPS_RES_RX_DROP) check("drop gap", 16'h0001, {15'h0000, $realtime - t_drop >= 180.0});
    end
    // the ceiling is checked last so nothing in this process runs after the verdict
    if (cycles >= 20000) begin
      n_errors++;
      close_out();
    end
  end

  initial begin
    {rst_n, req_valid, req_write, req_fifo_direct, req_burst, probe_enable, req_addr, req_wdata, lat} = '0;
    req_kind = hps_pkg::HPS_RES_IDENTITY;
    {n_tx, n_rx, n_drop, n_errors, tests_run, cycles} = '0;
    t_wr = -1.0e4;
    t_rx = -1.0e4;
    t_txs = -1.0e4;
    t_drop = -1.0e4;
    for (int i = 0; i < 128; i++) begin
      shadow[i] = {9'h000, 7'(i)};
      kind_of[i] = hps_pkg::HPS_RES_IDENTITY;
    end
    void'($urandom(18));
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    // every class written then read at once; probe fill chosen at random
    for (int k = 0; k < 16; k++) begin
      req(1'b1, hps_pkg::hps_res_e'(k), 7'(k * 4), 1'b0, 1'b0, 16'($urandom));
      req(1'b0, hps_pkg::hps_res_e'(k), 7'(k * 4), 1'b0, 1'b0, 16'h0000);
    end
    repeat (3) req(1'b1, hps_pkg::HPS_RES_TX_DATA, 7'h3c, 1'b1, 1'b0, 16'($urandom));
    req(1'b0, hps_pkg::HPS_RES_TX_LEVEL, 7'h1c, 1'b0, 1'b0, 16'h0000);
    req(1'b0, hps_pkg::HPS_RES_RX_DATA, 7'h30, 1'b1, 1'b0, 16'h0000);
    req(1'b0, hps_pkg::HPS_RES_RX_LEVEL, 7'h08, 1'b0, 1'b0, 16'h0000);
    for (int j = 0; j < 6; j++) req(1'b0, hps_pkg::HPS_RES_RX_DATA, 7'h30 + 7'(j % 2), 1'b1, 1'b1, 16'h0000);
    req(1'b0, hps_pkg::HPS_RES_RX_STATUS, 7'h34, 1'b0, 1'b0, 16'h0000);
    req(1'b0, hps_pkg::HPS_RES_RX_LEVEL, 7'h08, 1'b0, 1'b0, 16'h0000);
    // plain burst past the 16-word limit
    for (int j = 0; j < 18; j++) req(1'b0, hps_pkg::HPS_RES_OTHER_CFG, 7'h2d + 7'(j % 2), 1'b0, 1'b1, 16'h0000);
    req(1'b0, hps_pkg::HPS_RES_TX_STATUS, 7'h38, 1'b0, 1'b0, 16'h0000);
    req(1'b0, hps_pkg::HPS_RES_TX_LEVEL, 7'h1c, 1'b0, 1'b0, 16'h0000);
    repeat (2) req(1'b0, hps_pkg::HPS_RES_RX_DROP, 7'h0c, 1'b0, 1'b0, 16'h0000);
    @(negedge ref_clk);
    req_valid = 1'b0;
    repeat (60) @(posedge ref_clk);
    check("answers outstanding", 16'h0000, 16'(exp_q.size()));
    close_out();
  end
endmodule : testbench
